//--- status_pkg.sv
package status_pkg;

	// ==========================================================
	// register map
	localparam logic [6:0]  STATUS_ADDR  = 7'h21;
	localparam logic [15:0] STATUS_RESET = 16'h0000;

	// ==========================================================
	// field positions of the status word
	localparam int BIT_SC_LATCH   = 15;
	localparam int BIT_DOC_LATCH  = 14;
	localparam int BIT_COC_LATCH  = 13;
	localparam int BIT_COMM_ERR   = 12;
	localparam int BIT_RSVD       = 11;
	localparam int BIT_SEQ_ERR    = 10;
	localparam int BIT_SC_LIVE    = 7;
	localparam int BIT_DOC_LIVE   = 6;
	localparam int BIT_COC_LIVE   = 5;
	localparam int BIT_OVER_TEMP  = 4;
	localparam int BIT_CHARGE_FET_ON    = 3;
	localparam int BIT_CHARGE_FET_OFF   = 2;
	localparam int BIT_DISCHARGE_FET_ON    = 1;
	localparam int BIT_DISCHARGE_FET_OFF   = 0;
	// sticky group occupies bits 15:12 in this order
	localparam int STICKY_LSB     = 12;
	localparam int STICKY_W       = 4;

	// ==========================================================
	// serial frame: 8 header bits, 16 data bits, 8 crc bits
	localparam logic [5:0] CNT_HDR_LAST   = 6'h07;
	localparam logic [5:0] CNT_FRAME_LAST = 6'h1f;
	localparam logic [7:0] CRC_POLY       = 8'h07;
	localparam logic [7:0] CRC_INIT       = 8'h00;

	// ==========================================================
	// reset values of control state
	localparam logic [5:0] CNT_RESET      = 6'h00;
	localparam logic [1:0] ALARM_RESET_N  = 2'h3;

	// ==========================================================
	// types
	typedef struct packed {
		logic short_circuit_condition;
		logic discharge_overcurrent;
		logic charge_overcurrent;
		logic thermal_shutdown;
		logic sequencer_diag_error;
		logic fet_check_enable;
		logic charge_fet_on_check;
		logic charge_fet_off_check;
		logic discharge_fet_on_check;
		logic discharge_fet_off_check;
	} sense_t;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic mosi;
	} serial_in_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_DONE  = 2'b10
	} spi_state_t;

endpackage

//--- signal_sync.sv
`timescale 1ns/1ps
module signal_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] agree;

	// ==========================================================
	// three stage chain; s1 feeds only s2
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end
		else
		begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign agree = ~(s2_r ^ s3_r);

	// a new level is accepted only once two late stages agree
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			dout <= '0;
		else
			dout <= (agree & s3_r) | (~agree & dout);
	end
endmodule

//--- protection_event_status.sv
// Contract
// - a detected short circuit sets the sticky short-circuit latch in bit 15 until the host writes one to it.
// - while the short-circuit latch is set the first alarm pin is driven low.
// - a detected discharge overcurrent sets the sticky latch in bit 14, cleared only by writing one.
// - while the discharge-overcurrent latch is set one of the alarm pins is driven low.
// - a detected charge overcurrent sets the sticky latch in bit 13, cleared only by writing one.
// - while the charge-overcurrent latch is set one of the alarm pins is driven low.
// - a crc error in a complete serial write frame sets the communication error flag in bit 12 until written with one.
// - bit 10 reads one while the sequencer counter diagnostic reports a fault, zero otherwise.
// - bit 7 follows the short-circuit condition and clears itself when it is gone.
// - bit 6 follows the discharge overcurrent and clears itself when it is gone.
// - bit 5 follows the charge overcurrent and clears itself when it is gone.
// - bit 3 gives the charge fet turn-on check, one for pass, zero when failed or disabled.
// - bit 2 gives the charge fet turn-off check, one for pass, zero when failed or disabled.
// - bit 1 gives the discharge fet turn-on check, one for pass, zero when failed or disabled.
// - bit 0 gives the discharge fet turn-off check, one for pass, zero when failed or disabled.
`timescale 1ns/1ps
module protection_event_status (
	input  wire logic                    CLOCK,
	input  wire logic                    RESETN,
	input  wire status_pkg::sense_t      SENSE,
	input  wire status_pkg::serial_in_t  SERIAL_IN,
	output logic                         SDO_OUT,
	output logic                         SDO_OE,
	output logic                         FIRST_ALARM_PIN_N,
	output logic                         SECOND_ALARM_PIN_N
);
	import status_pkg::*;

	// ==========================================================
	// crc over a 24 bit stream, msb first
	function automatic logic [7:0] crc8_24(input logic [23:0] bits);
		logic [7:0] c;
		c = CRC_INIT;
		for (int i = 23; i >= 0; i--)
		begin
			if (c[7] ^ bits[i])
				c = {c[6:0], 1'b0} ^ CRC_POLY;
			else
				c = {c[6:0], 1'b0};
		end
		return c;
	endfunction

	// ==========================================================
	// reset release
	logic rst_meta_r;
	logic rst_n;

	always_ff @(posedge CLOCK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	// ==========================================================
	// input synchronisers
	sense_t     sense_s;
	serial_in_t ser_s;

	signal_sync #(
		.W($bits(sense_t))
	) u_sense_sync (
		.clk   (CLOCK),
		.rst_n (rst_n),
		.din   (SENSE),
		.dout  (sense_s)
	);

	signal_sync #(
		.W($bits(serial_in_t))
	) u_serial_sync (
		.clk   (CLOCK),
		.rst_n (rst_n),
		.din   (SERIAL_IN),
		.dout  (ser_s)
	);

	// ==========================================================
	// serial frame engine
	spi_state_t  state_r;
	logic [5:0]  bit_cnt_r;
	logic [31:0] rx_r;
	logic        sclk_prev_r;
	logic        sclk_rise;
	logic        selected;
	logic        shift_edge;
	logic        hdr_done;
	logic        frame_done;
	logic [7:0]  header;
	logic [31:0] word;

	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
			sclk_prev_r <= 1'b0;
		else
			sclk_prev_r <= ser_s.sclk;
	end

	assign sclk_rise  = ser_s.sclk & ~sclk_prev_r;
	assign selected   = ~ser_s.cs_n;
	assign shift_edge = (state_r == ST_SHIFT) && selected && sclk_rise;
	assign hdr_done   = shift_edge && (bit_cnt_r == CNT_HDR_LAST);
	assign frame_done = shift_edge && (bit_cnt_r == CNT_FRAME_LAST);
	assign header     = {rx_r[6:0], ser_s.mosi};
	assign word       = {rx_r[30:0], ser_s.mosi};

	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r   <= ST_IDLE;
			bit_cnt_r <= CNT_RESET;
			rx_r      <= '0;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					bit_cnt_r <= CNT_RESET;
					if (selected)
						state_r <= ST_SHIFT;
				end
				ST_SHIFT:
				begin
					// a frame cut short by chip select is dropped whole
					if (!selected)
						state_r <= ST_IDLE;
					else if (sclk_rise)
					begin
						rx_r      <= word;
						bit_cnt_r <= bit_cnt_r + 6'h01;
						if (bit_cnt_r == CNT_FRAME_LAST)
							state_r <= ST_DONE;
					end
				end
				ST_DONE:
				begin
					// surplus clocks are ignored until deselect
					if (!selected)
						state_r <= ST_IDLE;
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// ==========================================================
	// write decode
	logic        is_write;
	logic        crc_ok;
	logic        crc_err;
	logic        wr_ok;
	logic [15:0] wdata;

	assign is_write = word[31];
	assign crc_ok   = (crc8_24(word[31:8]) == word[7:0]);
	assign crc_err  = frame_done && is_write && !crc_ok;
	assign wr_ok    = frame_done && is_write && crc_ok && (word[30:24] == STATUS_ADDR);
	assign wdata    = word[23:8];

	// ==========================================================
	// status word
	logic [STICKY_W-1:0] sticky_r;
	logic [STICKY_W-1:0] sticky_set;
	logic [STICKY_W-1:0] sticky_clr;
	logic [2:0]          live_r;
	logic                over_temp_r;
	logic                seq_err_r;
	logic [3:0]          fet_r;
	logic [15:0]         status_word;

	assign sticky_set = {sense_s.short_circuit_condition,
	                     sense_s.discharge_overcurrent,
	                     sense_s.charge_overcurrent,
	                     crc_err};
	// only ones clear; the reserved and read-only lanes of wdata go nowhere
	assign sticky_clr = wr_ok ? wdata[STICKY_LSB +: STICKY_W] : '0;

	// set wins over a clear landing in the same cycle
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
			sticky_r <= STATUS_RESET[STICKY_LSB +: STICKY_W];
		else
			sticky_r <= sticky_set | (sticky_r & ~sticky_clr);
	end

	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			live_r      <= '0;
			over_temp_r <= 1'b0;
			seq_err_r   <= 1'b0;
		end
		else
		begin
			live_r[2]   <= sense_s.short_circuit_condition;
			live_r[1]   <= sense_s.discharge_overcurrent;
			live_r[0]   <= sense_s.charge_overcurrent;
			over_temp_r <= sense_s.thermal_shutdown;
			seq_err_r   <= sense_s.sequencer_diag_error;
		end
	end

	// a disabled check reads as fail rather than holding an old pass
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
			fet_r <= '0;
		else if (!sense_s.fet_check_enable)
			fet_r <= '0;
		else
			fet_r <= {sense_s.charge_fet_on_check,
			          sense_s.charge_fet_off_check,
			          sense_s.discharge_fet_on_check,
			          sense_s.discharge_fet_off_check};
	end

	always_comb
	begin
		status_word                              = STATUS_RESET;
		status_word[STICKY_LSB +: STICKY_W]      = sticky_r;
		status_word[BIT_RSVD]                    = 1'b0;
		status_word[BIT_SEQ_ERR]                 = seq_err_r;
		status_word[BIT_SC_LIVE]                 = live_r[2];
		status_word[BIT_DOC_LIVE]                = live_r[1];
		status_word[BIT_COC_LIVE]                = live_r[0];
		status_word[BIT_OVER_TEMP]               = over_temp_r;
		status_word[BIT_DISCHARGE_FET_OFF +: 4]           = fet_r;
	end

	// ==========================================================
	// alarm pins
	logic [1:0] alarm_n_r;

	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
			alarm_n_r <= ALARM_RESET_N;
		else
		begin
			alarm_n_r[1] <= ~sticky_r[BIT_SC_LATCH - STICKY_LSB];
			// overcurrent latches share the second pin so a short stays distinct
			alarm_n_r[0] <= ~(sticky_r[BIT_DOC_LATCH - STICKY_LSB]
			                | sticky_r[BIT_COC_LATCH - STICKY_LSB]);
		end
	end

	assign FIRST_ALARM_PIN_N  = alarm_n_r[1];
	assign SECOND_ALARM_PIN_N = alarm_n_r[0];

	// ==========================================================
	// read data path
	logic [22:0] tx_r;
	logic        sdo_r;
	logic        sdo_oe_r;
	logic [15:0] rdata;
	logic [23:0] rd_frame;

	// unmapped addresses answer zero
	assign rdata    = (header[6:0] == STATUS_ADDR) ? status_word : 16'h0000;
	assign rd_frame = {rdata, crc8_24({8'h00, rdata})};

	// the next bit goes out four to five system clocks after each rising edge, so synchroniser
	// latency leaves the host at most half an sclk period of margin
	always_ff @(posedge CLOCK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_r     <= '0;
			sdo_r    <= 1'b0;
			sdo_oe_r <= 1'b0;
		end
		else if (!selected || state_r == ST_IDLE)
		begin
			sdo_r    <= 1'b0;
			sdo_oe_r <= 1'b0;
		end
		else if (hdr_done && !header[7])
		begin
			sdo_r    <= rd_frame[23];
			tx_r     <= rd_frame[22:0];
			sdo_oe_r <= 1'b1;
		end
		else if (frame_done)
		begin
			sdo_r    <= 1'b0;
			sdo_oe_r <= 1'b0;
		end
		else if (shift_edge && sdo_oe_r)
		begin
			sdo_r <= tx_r[22];
			tx_r  <= {tx_r[21:0], 1'b0};
		end
	end

	assign SDO_OUT = sdo_r;
	assign SDO_OE  = sdo_oe_r;
endmodule

//--- protection_event_status_chk.sv
`timescale 1ns/1ps
// ==========
// port checker
module protection_event_status_chk (
	input wire logic                   CLOCK,
	input wire logic                   RESETN,
	input wire status_pkg::sense_t     SENSE,
	input wire status_pkg::serial_in_t SERIAL_IN,
	input wire logic                   SDO_OUT,
	input wire logic                   SDO_OE,
	input wire logic                   FIRST_ALARM_PIN_N,
	input wire logic                   SECOND_ALARM_PIN_N
);
	import status_pkg::*;
	logic [3:0] idle_r;
	logic [3:0] sc_age_r;
	logic [3:0] oc_age_r;
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESETN);
	// ==========
	// helpers: ages saturate so a stale cause cannot explain an alarm
	always_ff @(posedge CLOCK or negedge RESETN)
	begin
		if (!RESETN)
			idle_r <= 4'h0;
		else if (!SERIAL_IN.cs_n)
			idle_r <= 4'h0;
		else if (idle_r != 4'hf)
			idle_r <= idle_r + 4'h1;
	end
	always_ff @(posedge CLOCK or negedge RESETN)
	begin
		if (!RESETN)
			sc_age_r <= 4'hf;
		else if (SENSE.short_circuit_condition)
			sc_age_r <= 4'h0;
		else if (sc_age_r != 4'hf)
			sc_age_r <= sc_age_r + 4'h1;
	end
	always_ff @(posedge CLOCK or negedge RESETN)
	begin
		if (!RESETN)
			oc_age_r <= 4'hf;
		else if (SENSE.discharge_overcurrent || SENSE.charge_overcurrent)
			oc_age_r <= 4'h0;
		else if (oc_age_r != 4'hf)
			oc_age_r <= oc_age_r + 4'h1;
	end
	// ==========
	// properties
	sequence sc_held;
		SENSE.short_circuit_condition [*8];
	endsequence
	sequence oc_held;
		(SENSE.discharge_overcurrent || SENSE.charge_overcurrent) [*8];
	endsequence
	sequence cs_idle;
		SERIAL_IN.cs_n [*8];
	endsequence
	chk_alarm_one_set: assert property (sc_held |=> ##2 !FIRST_ALARM_PIN_N)
		else $error("first alarm pin not low after short circuit");
	chk_alarm_two_set: assert property (oc_held |=> ##2 !SECOND_ALARM_PIN_N)
		else $error("second alarm pin not low after overcurrent");
	// a latch may only drop as the result of a frame
	chk_alarm_one_hold: assert property ($rose(FIRST_ALARM_PIN_N) |-> idle_r < 4'ha)
		else $error("first alarm released without a write");
	chk_alarm_two_hold: assert property ($rose(SECOND_ALARM_PIN_N) |-> idle_r < 4'ha)
		else $error("second alarm released without a write");
	chk_alarm_one_cause: assert property ($fell(FIRST_ALARM_PIN_N) |-> sc_age_r < 4'hc)
		else $error("first alarm low without short circuit");
	chk_alarm_two_cause: assert property ($fell(SECOND_ALARM_PIN_N) |-> oc_age_r < 4'hc)
		else $error("second alarm low without overcurrent");
	chk_oe_idle: assert property (cs_idle |-> !SDO_OE)
		else $error("serial output driven while deselected");
	chk_sdo_quiet: assert property (!SDO_OE |-> !SDO_OUT)
		else $error("serial data not low while undriven");
endmodule

bind protection_event_status protection_event_status_chk chk_u (
	.CLOCK              (CLOCK),
	.RESETN             (RESETN),
	.SENSE              (SENSE),
	.SERIAL_IN          (SERIAL_IN),
	.SDO_OUT            (SDO_OUT),
	.SDO_OE             (SDO_OE),
	.FIRST_ALARM_PIN_N  (FIRST_ALARM_PIN_N),
	.SECOND_ALARM_PIN_N (SECOND_ALARM_PIN_N)
);

//--- status_host.sv
`timescale 1ns/1ps
// ==========
// host side of the serial link; sclk only runs inside frames
module status_host (
	output status_pkg::serial_in_t ser,
	input  wire logic              sdo
);
	import status_pkg::*;
	initial ser = 3'b100;
	function automatic logic [7:0] crc8(input logic [23:0] d, input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = n - 1; i >= 0; i--)
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction
	// n below 32 cuts the frame short
	task automatic frame(input logic [31:0] tx, input int n, output logic [23:0] rx);
		rx = 24'h000000;
		#7;
		ser.cs_n = 1'b0;
		for (int i = 0; i < n; i++)
		begin
			ser.mosi = tx[31 - i];
			#80 ser.sclk = 1'b1;
			if (i >= 8)
				rx = {rx[22:0], sdo};
			#80 ser.sclk = 1'b0;
		end
		#80 ser.cs_n = 1'b1;
		ser.mosi = ~ser.mosi;
		// frame length stays a whole number of system clocks, so pin edges never meet a sampling edge
		#193;
	endtask
	task automatic wr(input logic [7:0] hdr, input logic [15:0] d, input logic [7:0] bad, input int n);
		logic [23:0] rx;
		logic [15:0] dz;
		dz = d & 16'hf7ff;
		frame({hdr, dz, crc8({hdr, dz}, 24) ^ bad}, n, rx);
	endtask
endmodule

//--- test_protection_event_status.sv
`timescale 1ns/1ps
module test_protection_event_status;
	import status_pkg::*;
	logic       clock;
	logic       resetn;
	sense_t     sense;
	serial_in_t ser;
	logic       sdo_out;
	logic       sdo_oe;
	logic       first_alarm_pin_n;
	logic       second_alarm_pin_n;
	int         error_cnt = 0;
	int         num_checks = 0;
	int         cyc = 0;
	protection_event_status dut_u (
		.CLOCK              (clock),
		.RESETN             (resetn),
		.SENSE              (sense),
		.SERIAL_IN          (ser),
		.SDO_OUT            (sdo_out),
		.SDO_OE             (sdo_oe),
		.FIRST_ALARM_PIN_N  (first_alarm_pin_n),
		.SECOND_ALARM_PIN_N (second_alarm_pin_n)
	);
	status_host host_u (
		.ser (ser),
		// an undriven line shows the inverse, so a late or missing enable corrupts the read
		.sdo (sdo_oe ? sdo_out : ~sdo_out)
	);
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// ==========
	// helpers
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			$display("ERROR %s expected %h seen %h", what, exp, seen);
			error_cnt++;
		end
	endtask
	task automatic rd(input logic [15:0] exp);
		logic [23:0] rx;
		host_u.frame(32'h21000000, 32, rx);
		check("status", rx[23:8], exp);
		check("crc", {8'h00, rx[7:0]}, {8'h00, host_u.crc8({8'h00, exp}, 16)});
	endtask
	task automatic settle(input logic [9:0] s);
		@(negedge clock) sense <= s;
		repeat (12) @(posedge clock);
	endtask
	task automatic alarms(input logic [1:0] exp);
		check("alarms", {14'h0, first_alarm_pin_n, second_alarm_pin_n}, {14'h0, exp});
	endtask
	// ==========
	// scenarios
	task automatic t_reset();
		rd(16'h0000);
		alarms(2'b11);
		$display("test reset done");
	endtask
	task automatic t_events();
		settle(10'h3fa);
		rd(16'he4fa);
		alarms(2'b00);
		settle(10'h00a);
		rd(16'he000);
		alarms(2'b00);
		settle(10'h015);
		rd(16'he005);
		settle(10'h000);
		$display("test events done");
	endtask
	task automatic t_clear();
		host_u.wr(8'ha1, 16'h0000, 8'h00, 32);
		rd(16'he000);
		host_u.wr(8'ha1, 16'h0fff, 8'h00, 32);
		rd(16'he000);
		host_u.wr(8'ha1, 16'h8000, 8'h00, 32);
		rd(16'h6000);
		alarms(2'b10);
		host_u.wr(8'ha1, 16'h6000, 8'h00, 32);
		rd(16'h0000);
		alarms(2'b11);
		$display("test clear done");
	endtask
	task automatic t_comm();
		// a set latch shows whether a refused write still clears
		settle(10'h200);
		settle(10'h000);
		host_u.wr(8'ha1, 16'h8000, 8'h01, 32);
		rd(16'h9000);
		alarms(2'b01);
		host_u.wr(8'ha2, 16'h9000, 8'h00, 32);
		rd(16'h9000);
		host_u.wr(8'ha1, 16'h9000, 8'h00, 20);
		rd(16'h9000);
		host_u.wr(8'ha1, 16'h9000, 8'h00, 32);
		rd(16'h0000);
		alarms(2'b11);
		$display("test comm done");
	endtask
	// ==========
	// main sequence and hang guard
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			stop_test();
		end
	end
	initial
	begin
		sense = 10'h000;
		resetn = 1'b0;
		repeat (4) @(posedge clock);
		@(negedge clock) resetn <= 1'b1;
		repeat (10) @(posedge clock);
		t_reset();
		t_events();
		t_clear();
		t_comm();
		stop_test();
	end
endmodule
